// >>> verilog/ssi_pkg.sv
// Constants shared by the serial shift interface design.
package ssi_pkg;
  // Bus geometry.
  localparam int SSI_ADDR_W = 10;
  localparam int SSI_DATA_W = 32;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_IRQ_DISARM = 8'hDC;
  localparam logic [7:0] IDX_SHIFT_DATA = 8'hDD;
  localparam logic [7:0] IDX_PIN_CTRL = 8'hDE;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hDF;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hE0;
  localparam logic [7:0] IDX_BIT_COUNT = 8'hE1;
  // Pin control fields.
  localparam int CTRL_SOUT_OD = 0;
  localparam int CTRL_SCL_OD = 1;
  localparam int CTRL_SCL_BIT = 2;
  localparam int CTRL_W = 3;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  // Status and mask field.
  localparam int STAT_DONE = 0;
  // Shifter geometry and reset values.
  localparam int SHIFT_W = 8;
  localparam int COUNT_W = 4;
  localparam logic [3:0] COUNT_FULL = 4'h8;
  localparam logic [3:0] COUNT_LAST = 4'h7;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [3:0] COUNT_RESET = 4'h0;
endpackage : ssi_pkg

// >>> verilog/ssi_shifter.sv
// Serial shift interface: byte shifter on a sampled shift clock with an Avalon-MM register slave.
`timescale 1ns/1ps
module ssi_shifter
  import ssi_pkg::*;
#(
  parameter int SHIFT_BITS = SHIFT_W
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Avalon-MM slave.
  input wire logic [SSI_ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [SSI_DATA_W-1:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [SSI_DATA_W-1:0] avsReaddata,
  output logic avsWaitrequest,
  // Interrupt outputs.
  output logic irqOut,
  output logic serialIrqN,
  output logic countDoneOutput,
  // Shift clock pin, open drain.
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  // Serial data pins.
  input wire logic sinIn,
  output logic soutOut,
  output logic soutOe
);

  // The counter and the done output are sized for exactly one byte.
  if (SHIFT_BITS != SHIFT_W) begin : gBadWidth
    $error("ssi_shifter: SHIFT_BITS must be 8");
  end

  // Pin synchronisers; only the second stage and, for the clock, the third stage sclPrev_reg feed any logic.
  logic sclMeta_reg;
  logic sclSync_reg;
  logic sclPrev_reg;
  logic sinMeta_reg;
  logic sinSync_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclMeta_reg <= 1'b1;
      sclSync_reg <= 1'b1;
      sclPrev_reg <= 1'b1;
      sinMeta_reg <= 1'b1;
      sinSync_reg <= 1'b1;
    end else begin
      sclMeta_reg <= sclIn;
      sclSync_reg <= sclMeta_reg;
      sclPrev_reg <= sclSync_reg;
      sinMeta_reg <= sinIn;
      sinSync_reg <= sinMeta_reg;
    end
  end

  logic sclFall;
  assign sclFall = sclPrev_reg & ~sclSync_reg;

  // Bus handshake: every access is answered on its second cycle.
  logic busReq;
  logic resp_reg;
  logic resp_next;
  logic accept;
  logic [7:0] regIdx;
  logic laneWr;

  assign busReq = avsRead | avsWrite;
  assign accept = busReq & resp_reg;
  assign avsWaitrequest = busReq & ~resp_reg;
  assign regIdx = avsAddress[9:2];
  assign laneWr = avsWrite & accept & avsByteenable[0];

  always_comb begin
    resp_next = busReq & ~resp_reg;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      resp_reg <= 1'b0;
    end else begin
      resp_reg <= resp_next;
    end
  end

  logic dataWr;
  logic disarmWr;
  logic ctrlWr;
  logic statWr;
  logic maskWr;

  assign dataWr = laneWr & (regIdx == IDX_SHIFT_DATA);
  assign disarmWr = laneWr & (regIdx == IDX_IRQ_DISARM);
  assign ctrlWr = laneWr & (regIdx == IDX_PIN_CTRL);
  assign statWr = laneWr & (regIdx == IDX_IRQ_STATUS);
  assign maskWr = laneWr & (regIdx == IDX_IRQ_MASK);

  // Shifter core.
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic armed_reg;
  logic armed_next;
  logic clkEnable;
  logic eighthEdge;

  assign countDoneOutput = ~count_reg[3];
  assign clkEnable = countDoneOutput;
  assign eighthEdge = sclFall & clkEnable & (count_reg == COUNT_LAST) & ~dataWr;

  always_comb begin
    shift_next = shift_reg;
    count_next = count_reg;
    armed_next = armed_reg;
    if (dataWr) begin
      // A processor write wins over a coinciding clock edge.
      shift_next = avsWritedata[7:0];
      count_next = COUNT_RESET;
      armed_next = 1'b1;
    end else if (sclFall && clkEnable) begin
      // No start condition is searched for.
      shift_next = {shift_reg[6:0], sinSync_reg};
      count_next = count_reg + 4'h1;
    end
    if (disarmWr && !dataWr) begin
      armed_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift_reg <= SHIFT_RESET;
      count_reg <= COUNT_RESET;
      armed_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      count_reg <= count_next;
      armed_reg <= armed_next;
    end
  end

  // Falling-edge request: low while armed and the byte is complete.
  logic irqN_reg;
  logic irqN_next;

  always_comb begin
    irqN_next = ~(armed_next & (count_next == COUNT_FULL));
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqN_reg <= 1'b1;
    end else begin
      irqN_reg <= irqN_next;
    end
  end

  assign serialIrqN = irqN_reg;

  // Pin control, sticky status and mask.
  logic [CTRL_W-1:0] ctrl_reg;
  logic [CTRL_W-1:0] ctrl_next;
  logic stat_reg;
  logic stat_next;
  logic mask_reg;
  logic mask_next;

  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (ctrlWr) begin
      ctrl_next = avsWritedata[CTRL_W-1:0];
    end
    if (maskWr) begin
      mask_next = avsWritedata[STAT_DONE];
    end
    if (statWr && avsWritedata[STAT_DONE]) begin
      stat_next = 1'b0;
    end
    // A completion in the clearing cycle is kept.
    if (eighthEdge && armed_reg) begin
      stat_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
      stat_reg <= 1'b0;
      mask_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
    end
  end

  assign irqOut = stat_reg & mask_reg;

  // The shifter stops after eight bits, so the core may hold the clock low
  // for the acknowledge pulse without losing the byte.
  assign sclOut = 1'b0;
  assign sclOe = ctrl_reg[CTRL_SCL_OD] & ~ctrl_reg[CTRL_SCL_BIT];

  // The output pin cannot be a free open-drain line: the mode hands it to the shifter.
  assign soutOut = 1'b0;
  assign soutOe = ctrl_reg[CTRL_SOUT_OD] & ~shift_reg[7];

  // Read data.
  logic [SSI_DATA_W-1:0] rdata_reg;
  logic [SSI_DATA_W-1:0] rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (avsRead && !resp_reg) begin
      case (regIdx)
        IDX_SHIFT_DATA: rdata_next = {24'h000000, shift_reg};
        IDX_IRQ_DISARM: rdata_next = {31'h00000000, armed_reg};
        IDX_PIN_CTRL: rdata_next = {29'h00000000, ctrl_reg};
        IDX_IRQ_STATUS: rdata_next = {31'h00000000, stat_reg};
        IDX_IRQ_MASK: rdata_next = {31'h00000000, mask_reg};
        IDX_BIT_COUNT: rdata_next = {28'h0000000, count_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign avsReaddata = rdata_reg;

  // Checks.
  sequence fallSeen;
    sclFall && clkEnable && !dataWr;
  endsequence

  sequence lastBit;
    sclFall && clkEnable && !dataWr && (count_reg == COUNT_LAST) && armed_reg && !disarmWr;
  endsequence

  property shiftMsbFirst;
    @(posedge core_clk) disable iff (rst)
      fallSeen |=> (shift_reg == {$past(shift_reg[6:0]), $past(sinSync_reg)});
  endproperty

  msb_first_a: assert property (shiftMsbFirst)
    else $error("shift did not move toward the top bit");

  rise_noshift_a: assert property (@(posedge core_clk) disable iff (rst)
    (!sclFall && !dataWr) |=> $stable(shift_reg) && $stable(count_reg))
    else $error("shifter moved without a falling edge");

  count_stop_a: assert property (@(posedge core_clk) disable iff (rst)
    (count_reg == COUNT_FULL && !dataWr) |=> (count_reg == COUNT_FULL) && !countDoneOutput)
    else $error("clocking not blocked after eight bits");

  irq_fire_a: assert property (@(posedge core_clk) disable iff (rst)
    lastBit |=> !serialIrqN && stat_reg)
    else $error("no request on the eighth falling edge");

  reset_disarm_a: assert property (@(posedge core_clk)
    rst |=> !armed_reg && serialIrqN && (count_reg == COUNT_RESET))
    else $error("interrupt armed after reset");

  arm_write_a: assert property (@(posedge core_clk) disable iff (rst)
    dataWr |=> armed_reg && (count_reg == COUNT_RESET) && countDoneOutput)
    else $error("data write did not arm and clear");

  disarm_write_a: assert property (@(posedge core_clk) disable iff (rst)
    (disarmWr && !dataWr) |=> !armed_reg && serialIrqN)
    else $error("disarm write ignored");

  irq_edge_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(serialIrqN) |-> $past(sclFall) && (count_reg == COUNT_FULL))
    else $error("request fell without a completing edge");

  sout_drive_a: assert property (@(posedge core_clk) disable iff (rst)
    soutOe |-> ctrl_reg[CTRL_SOUT_OD] && !shift_reg[7] && !soutOut)
    else $error("serial output driven outside open-drain mode");

  stretch_a: assert property (@(posedge core_clk) disable iff (rst)
    ctrlWr && avsWritedata[CTRL_SCL_OD] && !avsWritedata[CTRL_SCL_BIT] |=> sclOe && !sclOut)
    else $error("clock stretch not applied");

  bus_answer_a: assert property (@(posedge core_clk) disable iff (rst)
    (busReq && !resp_reg) |=> !avsWaitrequest)
    else $error("bus access not answered on its second cycle");

  sequence readShift;
    avsRead && !resp_reg && (regIdx == IDX_SHIFT_DATA);
  endsequence

  count_step_a: assert property (@(posedge core_clk) disable iff (rst)
    fallSeen |=> (count_reg == $past(count_reg) + 4'h1))
    else $error("bit counter did not step on a falling edge");

  irq_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (!serialIrqN && !dataWr && !disarmWr) |=> !serialIrqN)
    else $error("request released without a processor write");

  stat_set_a: assert property (@(posedge core_clk) disable iff (rst)
    (eighthEdge && armed_reg) |=> stat_reg)
    else $error("completion not recorded in status");

  stat_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
    (stat_reg && !(statWr && avsWritedata[STAT_DONE])) |=> stat_reg)
    else $error("status bit lost without a clearing write");

  lane_ignore_a: assert property (@(posedge core_clk) disable iff (rst)
    (avsWrite && accept && !avsByteenable[0]) |=> $stable(armed_reg) && $stable(ctrl_reg) && $stable(mask_reg))
    else $error("write without lane zero changed a register");

  read_shift_a: assert property (@(posedge core_clk) disable iff (rst)
    readShift |=> (avsReaddata == {24'h000000, $past(shift_reg)}))
    else $error("shift register read back wrong");

endmodule : ssi_shifter

// >>> tb/ssi_peer.sv
// Remote serial master model that clocks a byte into and out of the shifter.
`timescale 1ns/1ps
module ssi_peer (
  // Clock.
  input wire logic core_clk,
  // Far-side view of the serial output line.
  input wire logic soutLine,
  // Driven pin levels and received byte.
  output logic sclDrive,
  output logic sinDrive,
  output logic [7:0] rxByte
);
  initial begin
    sclDrive = 1'b1;
    sinDrive = 1'b1;
    rxByte = 8'h00;
  end
  // The clock stands high outside frames; data is sampled just before each fall.
  task automatic send(input logic [7:0] txByte);
    @(posedge core_clk);
    for (int i = 7; i >= 0; i--) begin
      sinDrive <= txByte[i];
      repeat (2) @(posedge core_clk);
      rxByte <= {rxByte[6:0], soutLine};
      sclDrive <= 1'b0;
      repeat (4) @(posedge core_clk);
      sclDrive <= 1'b1;
      repeat (2) @(posedge core_clk);
    end
    // A released data line must not keep showing the last bit.
    sinDrive <= ~txByte[0];
  endtask : send
endmodule : ssi_peer

// >>> tb/ssi_shifter_tb.sv
// Self-checking bench for the serial shift interface.
`timescale 1ns/1ps
module ssi_shifter_tb;
  import ssi_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [SSI_ADDR_W-1:0] avsAddress = '0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [SSI_DATA_W-1:0] avsWritedata = '0;
  logic [3:0] avsByteenable = 4'h1;
  logic [SSI_DATA_W-1:0] avsReaddata;
  logic avsWaitrequest, irqOut, serialIrqN, countDoneOutput, sclOut, sclOe, soutOut, soutOe;
  logic sclDrive, sinDrive, sclLine, soutLine;
  logic [7:0] rxByte;
  logic [31:0] rdv;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  // Open-drain lines with pull-ups.
  assign sclLine = sclOe ? sclOut : sclDrive;
  assign soutLine = soutOe ? soutOut : 1'b1;
  ssi_shifter dut_u (.core_clk(core_clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .irqOut(irqOut),
    .serialIrqN(serialIrqN), .countDoneOutput(countDoneOutput), .sclIn(sclLine), .sclOut(sclOut),
    .sclOe(sclOe), .sinIn(sinDrive), .soutOut(soutOut), .soutOe(soutOe));
  ssi_peer peer_u (.core_clk(core_clk), .soutLine(soutLine), .sclDrive(sclDrive), .sinDrive(sinDrive),
    .rxByte(rxByte));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] gotv);
    compares++;
    if (gotv !== expv) begin
      $display("[ERR] %s expected %h seen %h", what, expv, gotv);
      n_fail++;
    end
  endtask : chk
  // Waitrequest and read data are taken at the rising edge, before that edge's own updates land.
  task automatic access(input logic wr, input logic [7:0] idx, input logic [7:0] wdata);
    @(posedge core_clk);
    avsAddress <= {idx, 2'b00};
    avsWritedata <= {24'h000000, wdata};
    avsWrite <= wr;
    avsRead <= ~wr;
    do @(posedge core_clk); while (avsWaitrequest !== 1'b0);
    rdv = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(negedge core_clk);
  endtask : access
  task automatic t_reset();
    chk("irqN", 1, serialIrqN);
    chk("done", 1, countDoneOutput);
    chk("soutOe", 0, soutOe);
    access(0, IDX_IRQ_DISARM, 0);
    chk("armed", 0, rdv);
    access(0, IDX_PIN_CTRL, 0);
    chk("ctrl", 4, rdv);
    access(0, 8'h10, 0);
    chk("unmapped", 0, rdv);
    peer_u.send(8'h3C);
    @(negedge core_clk);
    chk("irqN idle", 1, serialIrqN);
    access(0, IDX_SHIFT_DATA, 0);
    chk("rx unarmed", 8'h3C, rdv);
  endtask : t_reset
  task automatic t_shift();
    access(1, IDX_PIN_CTRL, 8'h05);
    access(1, IDX_IRQ_MASK, 8'h01);
    access(1, IDX_SHIFT_DATA, 8'hA5);
    chk("soutOe b7", 0, soutOe);
    access(0, IDX_BIT_COUNT, 0);
    chk("count clr", 0, rdv);
    access(0, IDX_IRQ_DISARM, 0);
    chk("armed", 1, rdv);
    peer_u.send(8'h96);
    @(negedge core_clk);
    chk("tx", 8'hA5, rxByte);
    chk("done", 0, countDoneOutput);
    chk("irqN", 0, serialIrqN);
    chk("irqOut", 1, irqOut);
    access(0, IDX_SHIFT_DATA, 0);
    chk("rx", 8'h96, rdv);
    access(0, IDX_BIT_COUNT, 0);
    chk("count", 8, rdv);
    peer_u.send(8'hFF);
    access(0, IDX_SHIFT_DATA, 0);
    chk("frozen", 8'h96, rdv);
    access(1, IDX_IRQ_MASK, 8'h00);
    chk("irq masked", 0, irqOut);
    access(1, IDX_IRQ_MASK, 8'h01);
    chk("irq unmasked", 1, irqOut);
    access(1, IDX_IRQ_STATUS, 8'h01);
    chk("irq clr", 0, irqOut);
  endtask : t_shift
  task automatic t_disarm();
    access(1, IDX_IRQ_DISARM, 8'h5A);
    chk("irqN off", 1, serialIrqN);
    access(1, IDX_PIN_CTRL, 8'h04);
    access(1, IDX_SHIFT_DATA, 8'h00);
    chk("soutOe od off", 0, soutOe);
    access(1, IDX_IRQ_DISARM, 8'h00);
    peer_u.send(8'h81);
    @(negedge core_clk);
    chk("irqN disarmed", 1, serialIrqN);
    access(0, IDX_IRQ_STATUS, 0);
    chk("status", 0, rdv);
    access(0, IDX_SHIFT_DATA, 0);
    chk("rx2", 8'h81, rdv);
  endtask : t_disarm
  task automatic t_stretch();
    access(1, IDX_PIN_CTRL, 8'h03);
    chk("stretch", 1, sclOe);
    access(1, IDX_PIN_CTRL, 8'h04);
    chk("release", 0, sclOe);
  endtask : t_stretch
  task automatic t_lane();
    @(posedge core_clk);
    avsByteenable <= 4'h0;
    access(1, IDX_PIN_CTRL, 8'h01);
    @(posedge core_clk);
    avsByteenable <= 4'h1;
    access(0, IDX_PIN_CTRL, 0);
    chk("lane0 off", 4, rdv);
    chk("sclOut", 0, sclOut);
    chk("soutOut", 0, soutOut);
  endtask : t_lane
  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    t_reset();
    t_shift();
    t_disarm();
    t_stretch();
    t_lane();
    final_report();
  end
endmodule : ssi_shifter_tb
